// ### tlipu_pkg.sv
// Shared constants and types for the two-level interrupt priority unit
package tlipu_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned TLIPU_ADDR_W = 3;
    localparam int unsigned TLIPU_DATA_W = 8;
    localparam int unsigned TLIPU_PC_W   = 21;
    localparam int unsigned TLIPU_ICNT_W = 2;
    localparam int unsigned TLIPU_WCNT_W = 2;

    // ==========================================================
    // Register offsets
    localparam logic [TLIPU_ADDR_W-1:0] OFS_IRQ_CTRL   = 3'h0;
    localparam logic [TLIPU_ADDR_W-1:0] OFS_RESET_CTRL = 3'h1;
    localparam logic [TLIPU_ADDR_W-1:0] OFS_SRC_FLAG   = 3'h2;
    localparam logic [TLIPU_ADDR_W-1:0] OFS_SRC_ENABLE = 3'h3;
    localparam logic [TLIPU_ADDR_W-1:0] OFS_SRC_LEVEL  = 3'h4;
    localparam logic [TLIPU_ADDR_W-1:0] OFS_STATUS     = 3'h5;

    // ==========================================================
    // Field positions
    localparam int unsigned BIT_HIGH_EN   = 7;
    localparam int unsigned BIT_LOW_EN    = 6;
    localparam int unsigned BIT_PSE       = 7;
    localparam int unsigned BIT_IN_HIGH   = 0;
    localparam int unsigned BIT_IN_LOW    = 1;
    localparam int unsigned BIT_BUSY      = 2;
    localparam int unsigned BIT_HI_PEND   = 3;
    localparam int unsigned BIT_LO_PEND   = 4;
    localparam logic [7:0]  CTRL_IMPL_MSK = 8'hC0;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] IRQ_CTRL_RST  = 8'h00;
    localparam logic       PSE_RST       = 1'b0;
    localparam logic       SRC_FLAG_RST  = 1'b0;
    localparam logic       SRC_EN_RST    = 1'b0;
    localparam logic       SRC_LEVEL_RST = 1'b1;

    // ==========================================================
    // Vectors and timing
    localparam logic [TLIPU_PC_W-1:0]   VEC_HIGH   = 21'h000008;
    localparam logic [TLIPU_PC_W-1:0]   VEC_LOW    = 21'h000018;
    localparam logic [TLIPU_ICNT_W-1:0] ICYC_LAST  = 2'h3;
    localparam logic [TLIPU_WCNT_W-1:0] ENTRY_LAST = 2'h2;

    typedef enum logic [1:0] {TLIPU_IDLE, TLIPU_WAIT} tlipu_state_t;

endpackage : tlipu_pkg

// ### tlipu_src_if.sv
// Bundle between the arbitration core and the per-source bit bank
`timescale 1ns/1ps
interface tlipu_src_if #(
    parameter int unsigned N = 8
) ();
    logic [N-1:0] event_in;
    logic [N-1:0] wdata;
    logic         wr_flag;
    logic         wr_enable;
    logic         wr_level;
    logic [N-1:0] flag;
    logic [N-1:0] enable;
    logic [N-1:0] level;

    modport bank (
        input  event_in, wdata, wr_flag, wr_enable, wr_level,
        output flag, enable, level
    );
    modport core (
        output event_in, wdata, wr_flag, wr_enable, wr_level,
        input  flag, enable, level
    );
endinterface : tlipu_src_if

// ### tlipu_src_bank.sv
// Per-source event flag, enable and level bits
`timescale 1ns/1ps
module tlipu_src_bank
    import tlipu_pkg::*;
#(
    parameter int unsigned N = 8
)
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    tlipu_src_if.bank   port
);

    typedef struct packed {
        logic [N-1:0] flag;
        logic [N-1:0] enable;
        logic [N-1:0] level;
    } tlipu_bank_t;

    tlipu_bank_t bank_reg;
    tlipu_bank_t bank_next;

    // ==========================================================
    // Bit update
    always_comb
    begin
        bank_next = bank_reg;
        if (port.wr_flag)
        begin
            bank_next.flag = port.wdata;
        end
        // An event in the same cycle as a software clear still lands
        bank_next.flag = bank_next.flag | port.event_in;
        if (port.wr_enable)
        begin
            bank_next.enable = port.wdata;
        end
        if (port.wr_level)
        begin
            bank_next.level = port.wdata;
        end
        // Pin zero has no level bit and always counts as high
        bank_next.level[0] = SRC_LEVEL_RST;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bank_reg.flag   <= {N{SRC_FLAG_RST}};
            bank_reg.enable <= {N{SRC_EN_RST}};
            bank_reg.level  <= {N{SRC_LEVEL_RST}};
        end
        else
        begin
            bank_reg <= bank_next;
        end
    end

    assign port.flag   = bank_reg.flag;
    assign port.enable = bank_reg.enable;
    assign port.level  = bank_reg.level;

endmodule : tlipu_src_bank

// ### tlipu_top.sv
// Two-level interrupt priority unit: registers, arbitration and vector entry
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module tlipu_top
    import tlipu_pkg::*;
#(
    parameter int unsigned  N_SRC       = 8,
    parameter logic [7:0]   PERIPH_MASK = 8'hF0
)
(
    input  wire logic                    SYS_CLK,
    input  wire logic                    RST_N,
    input  wire logic [TLIPU_ADDR_W-1:0] REG_ADDR,
    input  wire logic [TLIPU_DATA_W-1:0] REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output wire logic [TLIPU_DATA_W-1:0] REG_RDATA,
    input  wire logic [N_SRC-1:0]        SRC_EVENT,
    input  wire logic [TLIPU_PC_W-1:0]   CORE_PC,
    input  wire logic                    RET_EXEC,
    output wire logic                    ICYC_TICK,
    output wire logic                    VEC_LOAD,
    output wire logic [TLIPU_PC_W-1:0]   VEC_ADDR,
    output wire logic                    STACK_PUSH,
    output wire logic [TLIPU_PC_W-1:0]   STACK_DATA
);

    typedef struct packed {
        tlipu_state_t            state;
        logic [7:0]              ctrl;
        logic                    pse;
        logic                    in_high;
        logic                    in_low;
        logic                    lvl_high;
        logic [TLIPU_ICNT_W-1:0] icnt;
        logic [TLIPU_WCNT_W-1:0] wcnt;
        logic                    vec_load;
        logic                    push;
        logic [TLIPU_PC_W-1:0]   vec_addr;
        logic [TLIPU_PC_W-1:0]   ret_addr;
        logic [7:0]              rdata;
    } tlipu_core_t;

    tlipu_core_t core_reg;
    tlipu_core_t core_next;

    tlipu_src_if #(.N(N_SRC)) src ();

    logic [N_SRC-1:0] pend;
    logic [N_SRC-1:0] hi_pend;
    logic [N_SRC-1:0] lo_pend;
    logic [N_SRC-1:0] grp_gate;
    logic             hi_ok;
    logic             lo_ok;
    logic             tick;
    logic             take;
    logic             ctrl_wr;

    // ==========================================================
    // Source bit bank
    assign src.event_in  = SRC_EVENT;
    assign src.wdata     = REG_WDATA[N_SRC-1:0];
    assign src.wr_flag   = REG_WR && (REG_ADDR == OFS_SRC_FLAG);
    assign src.wr_enable = REG_WR && (REG_ADDR == OFS_SRC_ENABLE);
    assign src.wr_level  = REG_WR && (REG_ADDR == OFS_SRC_LEVEL);

    tlipu_src_bank #(
        .N      (N_SRC)
    ) u_bank (
        .clk    (SYS_CLK),
        .rst_n  (RST_N),
        .port   (src.bank)
    );

    // ==========================================================
    // Request qualification
    assign pend     = src.flag & src.enable;
    assign hi_pend  = pend & src.level;
    assign lo_pend  = pend & ~src.level;
    // Non-peripheral sources bypass the group enable
    assign grp_gate = ~PERIPH_MASK[N_SRC-1:0] | {N_SRC{core_reg.ctrl[BIT_LOW_EN]}};
    assign tick     = (core_reg.icnt == ICYC_LAST);
    assign ctrl_wr  = REG_WR && (REG_ADDR == OFS_IRQ_CTRL);

    always_comb
    begin
        if (core_reg.pse)
        begin
            hi_ok = (|hi_pend) && core_reg.ctrl[BIT_HIGH_EN];
            // A low request never nests inside a high handler
            lo_ok = (|lo_pend) && core_reg.ctrl[BIT_LOW_EN]
                    && core_reg.ctrl[BIT_HIGH_EN] && !core_reg.in_high;
        end
        else
        begin
            hi_ok = core_reg.ctrl[BIT_HIGH_EN] && (|(pend & grp_gate));
            lo_ok = 1'b0;
        end
    end

    // Requests are sampled only on instruction boundaries
    assign take = tick && (core_reg.state == TLIPU_IDLE) && (hi_ok || lo_ok);

    // ==========================================================
    // Next state
    always_comb
    begin
        core_next          = core_reg;
        core_next.vec_load = 1'b0;
        core_next.push     = 1'b0;
        core_next.rdata    = 8'h00;
        core_next.icnt     = tick ? '0 : core_reg.icnt + 1'b1;

        if (REG_WR)
        begin
            case (REG_ADDR)
                OFS_IRQ_CTRL:   core_next.ctrl = REG_WDATA & CTRL_IMPL_MSK;
                OFS_RESET_CTRL: core_next.pse  = REG_WDATA[BIT_PSE];
                default:        core_next.ctrl = core_next.ctrl;
            endcase
        end

        if (REG_RD)
        begin
            case (REG_ADDR)
                OFS_IRQ_CTRL:   core_next.rdata = core_reg.ctrl;
                OFS_RESET_CTRL: core_next.rdata = {core_reg.pse, 7'h00};
                OFS_SRC_FLAG:   core_next.rdata = 8'(src.flag);
                OFS_SRC_ENABLE: core_next.rdata = 8'(src.enable);
                OFS_SRC_LEVEL:  core_next.rdata = 8'(src.level);
                OFS_STATUS:
                begin
                    core_next.rdata[BIT_IN_HIGH] = core_reg.in_high;
                    core_next.rdata[BIT_IN_LOW]  = core_reg.in_low;
                    core_next.rdata[BIT_BUSY]    = (core_reg.state != TLIPU_IDLE);
                    core_next.rdata[BIT_HI_PEND] = hi_ok;
                    core_next.rdata[BIT_LO_PEND] = lo_ok;
                end
                default:        core_next.rdata = 8'h00;
            endcase
        end

        // Return restores the enable of the level being left
        if (RET_EXEC)
        begin
            if (core_reg.in_high)
            begin
                core_next.ctrl[BIT_HIGH_EN] = 1'b1;
                core_next.in_high           = 1'b0;
            end
            else if (core_reg.in_low)
            begin
                core_next.ctrl[BIT_LOW_EN] = 1'b1;
                core_next.in_low           = 1'b0;
            end
        end

        case (core_reg.state)
            TLIPU_IDLE:
            begin
                if (take)
                begin
                    core_next.state    = TLIPU_WAIT;
                    core_next.wcnt     = '0;
                    core_next.lvl_high = hi_ok;
                    // Hardware clear beats a software write this cycle
                    if (hi_ok)
                    begin
                        core_next.ctrl[BIT_HIGH_EN] = 1'b0;
                        core_next.in_high           = 1'b1;
                    end
                    else
                    begin
                        core_next.ctrl[BIT_LOW_EN] = 1'b0;
                        core_next.in_low           = 1'b1;
                    end
                end
            end
            TLIPU_WAIT:
            begin
                if (tick)
                begin
                    if (core_reg.wcnt == ENTRY_LAST)
                    begin
                        core_next.state    = TLIPU_IDLE;
                        core_next.vec_load = 1'b1;
                        core_next.push     = 1'b1;
                        core_next.ret_addr = CORE_PC;
                        core_next.vec_addr = core_reg.lvl_high ? VEC_HIGH : VEC_LOW;
                    end
                    else
                    begin
                        core_next.wcnt = core_reg.wcnt + 1'b1;
                    end
                end
            end
            default:
            begin
                core_next.state = TLIPU_IDLE;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            core_reg          <= '0;
            core_reg.state    <= TLIPU_IDLE;
            core_reg.ctrl     <= IRQ_CTRL_RST;
            core_reg.pse      <= PSE_RST;
            core_reg.vec_addr <= VEC_HIGH;
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    assign REG_RDATA  = core_reg.rdata;
    assign ICYC_TICK  = tick;
    assign VEC_LOAD   = core_reg.vec_load;
    assign VEC_ADDR   = core_reg.vec_addr;
    assign STACK_PUSH = core_reg.push;
    assign STACK_DATA = core_reg.ret_addr;

    // ==========================================================
    // Checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    vec_two_level_a: assert property (
        VEC_LOAD && core_reg.pse && $past(core_reg.pse, 13)
        |-> (VEC_ADDR == (core_reg.lvl_high ? VEC_HIGH : VEC_LOW)))
        else $error("two-level vector address wrong");

    vec_compat_a: assert property (
        take && !core_reg.pse |-> ##13 (VEC_LOAD && VEC_ADDR == VEC_HIGH))
        else $error("compatibility mode did not vector to high address");

    preempt_low_a: assert property (
        tick && core_reg.state == TLIPU_IDLE && core_reg.pse && core_reg.in_low
        && (|hi_pend) && core_reg.ctrl[BIT_HIGH_EN]
        |=> core_reg.in_high && core_reg.in_low && core_reg.lvl_high)
        else $error("high request failed to preempt low handler");

    level_zero_a: assert property (
        src.level[0])
        else $error("pin zero level bit not fixed high");

    scheme_off_a: assert property (
        !core_reg.pse |-> !lo_ok)
        else $error("low level active with scheme disabled");

    level_gate_a: assert property (
        take && core_reg.pse && !hi_ok |-> core_reg.ctrl[BIT_LOW_EN] && (|lo_pend))
        else $error("low request taken without low enable");

    need_all_a: assert property (
        take |-> core_reg.ctrl[BIT_HIGH_EN] && (|pend))
        else $error("vectoring without flag, enable and global enable");

    group_gate_a: assert property (
        take && !core_reg.pse && !core_reg.ctrl[BIT_LOW_EN]
        |-> (|(pend & ~PERIPH_MASK[N_SRC-1:0])))
        else $error("peripheral group taken while group disabled");

    clear_enable_a: assert property (
        take |=> !(core_reg.lvl_high ? core_reg.ctrl[BIT_HIGH_EN]
                                     : core_reg.ctrl[BIT_LOW_EN]))
        else $error("global enable not cleared on entry");

    push_return_a: assert property (
        VEC_LOAD |-> STACK_PUSH && (STACK_DATA == $past(CORE_PC)))
        else $error("return address not pushed with vector load");

    ret_restore_a: assert property (
        RET_EXEC && core_reg.in_high && core_reg.state == TLIPU_IDLE && !take
        |=> core_reg.ctrl[BIT_HIGH_EN] && !core_reg.in_high)
        else $error("return did not restore high enable");

    entry_latency_a: assert property (
        take |-> !VEC_LOAD [*8] ##1 !VEC_LOAD [*5] ##1 VEC_LOAD)
        else $error("entry latency not three instruction cycles");

    flag_sets_a: assert property (
        |SRC_EVENT |=> ((src.flag & $past(SRC_EVENT)) == $past(SRC_EVENT)))
        else $error("event did not set its flag");

    enable_mask_a: assert property (
        take && core_reg.pse
        |-> (hi_ok && (|(src.flag & src.enable & src.level)))
            || (lo_ok && (|(src.flag & src.enable & ~src.level))))
        else $error("disabled source caused vectoring");

    low_nest_a: assert property (
        core_reg.in_high && core_reg.pse |-> !lo_ok)
        else $error("low request nested inside high handler");

    flag_sticky_a: assert property (
        !src.wr_flag |=> ((src.flag & $past(src.flag)) == $past(src.flag)))
        else $error("flag cleared without software write");

    high_first_a: assert property (
        take && hi_ok && lo_ok |=> core_reg.lvl_high && !core_reg.in_low
                                   ##0 (|lo_pend || !core_reg.pse))
        else $error("low request served before high request");

    low_kept_off_a: assert property (
        RET_EXEC && core_reg.in_high && core_reg.in_low && !ctrl_wr
        |=> !core_reg.ctrl[BIT_LOW_EN] && core_reg.in_low)
        else $error("low enable restored while low handler still active");

    low_vector_c: cover property (VEC_LOAD && VEC_ADDR == VEC_LOW);
    preempt_c:    cover property (core_reg.in_high && core_reg.in_low);
    compat_c:     cover property (VEC_LOAD && !core_reg.pse);
    return_c:     cover property (RET_EXEC && core_reg.in_low);

endmodule : tlipu_top

// ### tlipu_core_model.sv
// Behavioural model of the core fetch unit that faces the interrupt unit
`timescale 1ns/1ps
// ==========================================================
// Core fetch model
module tlipu_core_model
    import tlipu_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  vec_load,
    input  wire logic [TLIPU_PC_W-1:0] vec_addr,
    input  wire logic                  stack_push,
    input  wire logic [TLIPU_PC_W-1:0] stack_data,
    input  wire logic                  ret_req,
    output logic      [TLIPU_PC_W-1:0] core_pc,
    output logic                       ret_exec
);
    logic [TLIPU_PC_W-1:0] stack_mem [$];

    // Counting by one on each clock without a vector load or return keeps each return address distinct
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            core_pc  <= 21'h000100;
            ret_exec <= 1'b0;
            stack_mem.delete();
        end
        else
        begin
            ret_exec <= ret_req;
            if (stack_push)
                stack_mem.push_back(stack_data);
            if (vec_load)
                core_pc <= vec_addr;
            else if (ret_exec && stack_mem.size() > 0)
                core_pc <= stack_mem.pop_back();
            else
                core_pc <= core_pc + 21'h000001;
        end
    end
endmodule : tlipu_core_model

// ### tlipu_tb_top.sv
// Self-checking testbench of the two-level interrupt priority unit
`timescale 1ns/1ps
module tlipu_tb_top;
    import tlipu_pkg::*;
    // ==========================================================
    // Signals
    logic                    sys_clk   = 1'b0;
    logic                    rst_n     = 1'b0;
    logic                    reg_wr    = 1'b0;
    logic                    reg_rd    = 1'b0;
    logic                    ret_req   = 1'b0;
    logic [TLIPU_ADDR_W-1:0] reg_addr  = 3'h0;
    logic [TLIPU_DATA_W-1:0] reg_wdata = 8'h00;
    logic [7:0]              src_event = 8'h00;
    logic [TLIPU_DATA_W-1:0] reg_rdata;
    logic [TLIPU_PC_W-1:0]   core_pc;
    logic [TLIPU_PC_W-1:0]   vec_addr;
    logic [TLIPU_PC_W-1:0]   stack_data;
    logic [TLIPU_PC_W-1:0]   seen_pc;
    logic                    ret_exec;
    logic                    icyc_tick;
    logic                    vec_load;
    logic                    stack_push;
    logic [7:0]              lvl_rnd;
    int                      miscompares  = 0;
    int                      total_checks = 0;
    int                      lat;
    int                      src;

    always #10 sys_clk = ~sys_clk;

    tlipu_top i_tlipu_top (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .SRC_EVENT(src_event), .CORE_PC(core_pc), .RET_EXEC(ret_exec), .ICYC_TICK(icyc_tick),
        .VEC_LOAD(vec_load), .VEC_ADDR(vec_addr), .STACK_PUSH(stack_push),
        .STACK_DATA(stack_data));

    tlipu_core_model i_tlipu_core_model (.clk(sys_clk), .rst_n(rst_n), .vec_load(vec_load),
        .vec_addr(vec_addr), .stack_push(stack_push), .stack_data(stack_data),
        .ret_req(ret_req), .core_pc(core_pc), .ret_exec(ret_exec));

    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    // Whole-register writes only; no memory-to-memory style updates
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, e);
    endtask : rd_chk

    task automatic fire(input logic [7:0] m);
        @(posedge sys_clk);
        src_event <= m;
        @(posedge sys_clk);
        src_event <= 8'h00;
    endtask : fire

    task automatic ret();
        @(posedge sys_clk);
        ret_req <= 1'b1;
        @(posedge sys_clk);
        ret_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : ret

    // Return address is the core counter of the cycle before the load
    task automatic wait_vec(input int limit, output int n, output logic [20:0] pc_prev);
        logic [20:0] last;
        n    = 0;
        last = core_pc;
        repeat (limit)
        begin
            @(negedge sys_clk);
            n++;
            if (vec_load === 1'b1)
            begin
                pc_prev = last;
                return;
            end
            last = core_pc;
        end
        n = -1;
    endtask : wait_vec

    task automatic expect_vec(input logic [20:0] e);
        wait_vec(40, lat, seen_pc);
        chk(lat > 0, 1'b1);
        chk(vec_addr, e);
        chk(stack_push, 1'b1);
        chk(stack_data, seen_pc);
    endtask : expect_vec

    task automatic expect_none();
        wait_vec(30, lat, seen_pc);
        chk(lat, -1);
    endtask : expect_none

    function automatic logic [20:0] exp_vec(input logic pse, input logic lvl);
        return (pse && !lvl) ? VEC_LOW : VEC_HIGH;
    endfunction : exp_vec

    function automatic logic [7:0] ctrl_after(input logic pse, input logic lvl,
                                              input logic [7:0] c);
        if (pse && !lvl)
            return c & ~(8'h01 << BIT_LOW_EN);
        return c & ~(8'h01 << BIT_HIGH_EN);
    endfunction : ctrl_after

    // ==========================================================
    // Watchdog: the whole sequence needs a few hundred clocks
    initial
    begin
        #(20 * 20000);
        miscompares++;
        print_verdict();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(22));
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        // First instruction boundary falls on the fourth edge after release
        for (int k = 0; k < 4; k++)
        begin
            @(negedge sys_clk);
            chk(icyc_tick, k == 3);
        end
        for (int a = 0; a < 8; a++)
            rd_chk(a[2:0], (a == OFS_SRC_LEVEL) ? 8'hFF : 8'h00);
        fire(8'h20);
        expect_none();
        rd_chk(OFS_SRC_FLAG, 8'h20);
        wr(OFS_SRC_FLAG, 8'h00);
        rd_chk(OFS_SRC_FLAG, 8'h00);
        // Compatibility mode, random source, level and phase to the tick
        for (int i = 0; i < 6; i++)
        begin
            src     = $urandom % 4;
            lvl_rnd = 8'($urandom);
            wr(OFS_SRC_LEVEL, lvl_rnd);
            wr(OFS_SRC_FLAG, 8'h00);
            wr(OFS_SRC_ENABLE, 8'h01 << src);
            wr(OFS_IRQ_CTRL, 8'h80);
            repeat ($urandom % 8) @(posedge sys_clk);
            fire(8'h01 << src);
            expect_vec(exp_vec(1'b0, lvl_rnd[src]));
            chk(lat >= 13 && lat <= 18, 1'b1);
            rd_chk(OFS_IRQ_CTRL, ctrl_after(1'b0, lvl_rnd[src], 8'h80));
            wr(OFS_SRC_FLAG, 8'h00);
            ret();
            rd_chk(OFS_IRQ_CTRL, 8'h80);
            wr(OFS_IRQ_CTRL, 8'h00);
        end
        wr(OFS_SRC_ENABLE, 8'h10);
        wr(OFS_IRQ_CTRL, 8'h80);
        fire(8'h10);
        expect_none();
        wr(OFS_IRQ_CTRL, 8'hC0);
        expect_vec(VEC_HIGH);
        rd_chk(OFS_IRQ_CTRL, 8'h40);
        wr(OFS_SRC_FLAG, 8'h00);
        ret();
        // Two-level mode: source 2 low, source 3 high
        wr(OFS_IRQ_CTRL, 8'h00);
        wr(OFS_RESET_CTRL, 8'h80);
        rd_chk(OFS_RESET_CTRL, 8'h80);
        wr(OFS_SRC_LEVEL, 8'hFB);
        wr(OFS_SRC_ENABLE, 8'h0C);
        wr(OFS_IRQ_CTRL, 8'h40);
        fire(8'h04);
        expect_none();
        wr(OFS_IRQ_CTRL, 8'hC0);
        expect_vec(exp_vec(1'b1, 1'b0));
        rd_chk(OFS_IRQ_CTRL, ctrl_after(1'b1, 1'b0, 8'hC0));
        fire(8'h08);
        expect_vec(exp_vec(1'b1, 1'b1));
        rd_chk(OFS_IRQ_CTRL, 8'h00);
        rd_chk(OFS_STATUS, 8'h03);
        wr(OFS_SRC_FLAG, 8'h00);
        ret();
        rd_chk(OFS_IRQ_CTRL, 8'h80);
        ret();
        rd_chk(OFS_IRQ_CTRL, 8'hC0);
        // Both levels eligible together
        wr(OFS_IRQ_CTRL, 8'h00);
        fire(8'h0C);
        wr(OFS_IRQ_CTRL, 8'hC0);
        expect_vec(VEC_HIGH);
        rd_chk(OFS_IRQ_CTRL, 8'h40);
        wr(OFS_SRC_FLAG, 8'h04);
        ret();
        expect_vec(VEC_LOW);
        wr(OFS_SRC_FLAG, 8'h00);
        ret();
        // One enable cleared, the other source still served
        wr(OFS_SRC_ENABLE, 8'h08);
        fire(8'h04);
        expect_none();
        fire(8'h08);
        expect_vec(VEC_HIGH);
        print_verdict();
    end
endmodule : tlipu_tb_top
